/* shared/sar_pkg.sv */
// constants shared by both ends of the converter serial readout link
// assumes a 200 MHz system clock on both ends
package sar_pkg;
   // ******************************
   // frame layout
   // ******************************
   localparam int RES_W = 14;
   localparam int SUB_W = 2;
   localparam int WORD_W = RES_W + SUB_W;
   localparam int LEAD_ZEROS = 8;
   localparam int FRAME_EDGES = LEAD_ZEROS + WORD_W;
   localparam int HOLD_EDGE = 6;
   localparam int FIRST_DATA_EDGE = LEAD_ZEROS;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] CNT_HOLD = CNT_W'(HOLD_EDGE - 1);
   localparam logic [CNT_W-1:0] CNT_DATA = CNT_W'(FIRST_DATA_EDGE - 1);
   localparam logic [CNT_W-1:0] CNT_FRAME = CNT_W'(FRAME_EDGES);
   localparam int FIFO_DEPTH = 4;

   // ******************************
   // timing
   // ******************************
   localparam int CLK_NS = 5;
   localparam int SCLK_PERIOD_NS = 208;
   localparam int CS_SETUP_NS = 100;
   localparam int CS_HIGH_NS = 50;
   localparam int TMR_W = 8;
   localparam logic [TMR_W-1:0] HALF_CYC =
      TMR_W'((SCLK_PERIOD_NS / 2 + CLK_NS - 1) / CLK_NS);
   localparam logic [TMR_W-1:0] SETUP_CYC = TMR_W'((CS_SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TMR_W-1:0] GAP_CYC = TMR_W'((CS_HIGH_NS + CLK_NS - 1) / CLK_NS);
endpackage : sar_pkg

/* shared/sar_link_if.sv */
// three-wire link between serial master and converter
// assumes the bench joins both modports; data line floats low when undriven
`timescale 1ns/1ps
interface sar_link_if;
   logic sel_n;
   logic sclk;
   logic dout;
   logic dout_oe;
   logic dout_line;

   // resolved data wire, weak pull to zero when released
   assign dout_line = dout_oe & dout;

   modport device (input sel_n, input sclk, output dout, output dout_oe);
   modport host (output sel_n, output sclk, input dout_line);
endinterface : sar_link_if

/* logic/sar_fifo.sv */
// small valid/ready fifo held in flip-flops
// assumes one clock domain and depth of a power of two
`timescale 1ns/1ps
module sar_fifo #(
   parameter int W = 16,
   parameter int D = 4
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   // honest flags straight from the fill count
   assign in_ready_o = (count != (AW+1)'(D));
   assign out_valid_o = (count != '0);
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign out_data_o = mem[rd_ptr];

   // storage
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // pointers and count
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
         if (push & ~pop) count <= count + 1'b1;
         else if (pop & ~push) count <= count - 1'b1;
      end
   end
endmodule : sar_fifo

/* logic/sar_dev.sv */
// converter end: conversion control and serial readout of a 14-bit result
// assumes select and serial clock come from a foreign domain on the link
//
// Contract
// - select high: shutdown, data output released
// - select low: fully powered
// - select fall starts conversion, serial clock advances
// - select fall: output enabled driving low
// - sixth clock fall ends sampling
// - result MSB first after eighth fall
// - 24 falls: 8 zeros, 14 bits, 2 sub-bits
// - extra clocks give zeros, converter untouched
// - select high after read resets, shuts down
// - select high mid-conversion aborts at once
// - master reselects after minimum high time
// - master clock at most 4.8MHz, 40-60% duty
// - master avoids clock below 100kHz
// - result straight binary, 16384 codes
// - master cycles select between conversions
// - output changes only on clock falls
`timescale 1ns/1ps
module sar_dev
   import sar_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // link
   sar_link_if.device link,
   // analog stand-in: code the capacitor array would settle to
   input wire logic [RES_W-1:0] analog_input_i,
   input wire logic sub_bit_high_i,
   input wire logic sub_bit_low_i,
   // status
   output logic powered_o,
   output logic sample_held_o,
   output logic done_o,
   output logic abort_o
);
   typedef enum logic [2:0] {
      DEV_OFF,
      DEV_ACQ,
      DEV_CONV,
      DEV_READ
   } sar_dev_state_t;

   sar_dev_state_t state;
   logic sel_m;
   logic sel_s;
   logic sel_d;
   logic sclk_m;
   logic sclk_s;
   logic sclk_d;
   logic sel_fall;
   logic sel_rise;
   logic sclk_fall;
   logic [CNT_W-1:0] edge_cnt;
   logic [WORD_W-1:0] sampling_cap_array;
   logic [WORD_W-1:0] ain_m;
   logic [WORD_W-1:0] ain_s;
   logic [WORD_W-1:0] shreg;
   logic dout;
   logic dout_oe;

   // ******************************
   // pin synchronisers
   // ******************************

   // three flops per pin; sel_s, sclk_s and the delayed sel_d, sclk_d feed logic
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sel_m <= 1'b1;
         sel_s <= 1'b1;
         sel_d <= 1'b1;
         sclk_m <= 1'b0;
         sclk_s <= 1'b0;
         sclk_d <= 1'b0;
      end else begin
         sel_m <= link.sel_n;
         sel_s <= sel_m;
         sel_d <= sel_s;
         sclk_m <= link.sclk;
         sclk_s <= sclk_m;
         sclk_d <= sclk_s;
      end
   end

   // analog stand-in pins, two flops only; the code must stay steady
   // around the sixth fall, a code moving right at capture may tear
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ain_m <= '0;
         ain_s <= '0;
      end else begin
         ain_m <= {analog_input_i, sub_bit_high_i, sub_bit_low_i};
         ain_s <= ain_m;
      end
   end

   // edge detection on synchronised levels
   assign sel_fall = sel_d & ~sel_s;
   assign sel_rise = ~sel_d & sel_s;
   // clock falls count only while selected
   assign sclk_fall = sclk_d & ~sclk_s & ~sel_s;

   // ******************************
   // conversion sequence
   // ******************************

   // select high overrides everything, so an abort needs no extra path
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state <= DEV_OFF;
      end else if (sel_s) begin
         state <= DEV_OFF;
      end else begin
         case (state)
            DEV_OFF: begin
               if (sel_fall) state <= DEV_ACQ;
            end
            DEV_ACQ: begin
               if (sclk_fall && edge_cnt == CNT_HOLD) state <= DEV_CONV;
            end
            DEV_CONV: begin
               if (sclk_fall && edge_cnt == CNT_DATA) state <= DEV_READ;
            end
            DEV_READ: begin
               state <= DEV_READ; // trailing clocks stay here
            end
            default: begin
               state <= DEV_OFF;
            end
         endcase
      end
   end

   // falling-edge count, saturates so extra clocks do nothing
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         edge_cnt <= '0;
      end else if (sel_s) begin
         edge_cnt <= '0;
      end else if (sclk_fall && edge_cnt != CNT_FRAME) begin
         edge_cnt <= edge_cnt + 1'b1;
      end
   end

   // held sample: code is taken at the sixth fall, straight binary
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sampling_cap_array <= '0;
      end else if (sel_s) begin
         sampling_cap_array <= '0;
      end else if (state == DEV_ACQ && sclk_fall && edge_cnt == CNT_HOLD) begin
         sampling_cap_array <= ain_s;
      end
   end

   // ******************************
   // serial output
   // ******************************

   // shifter fills with zeros, so trailing clocks read zeros
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         shreg <= '0;
         dout <= 1'b0;
      end else if (sel_s) begin
         shreg <= '0;
         dout <= 1'b0;
      end else if (sel_fall) begin
         dout <= 1'b0;
      end else if (sclk_fall) begin
         if (state == DEV_CONV && edge_cnt == CNT_DATA) begin
            dout <= sampling_cap_array[WORD_W-1];
            shreg <= {sampling_cap_array[WORD_W-2:0], 1'b0};
         end else if (state == DEV_READ) begin
            dout <= shreg[WORD_W-1];
            shreg <= {shreg[WORD_W-2:0], 1'b0};
         end else begin
            dout <= 1'b0; // leading zeros
         end
      end
   end

   // output enable follows synchronised select
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         dout_oe <= 1'b0;
      end else begin
         dout_oe <= ~sel_s;
      end
   end

   assign link.dout = dout;
   assign link.dout_oe = dout_oe;

   // ******************************
   // status
   // ******************************

   // power mode on while select is low or the state is not yet DEV_OFF
   assign powered_o = (state != DEV_OFF) || !sel_s;

   // one-cycle event flags
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sample_held_o <= 1'b0;
         done_o <= 1'b0;
         abort_o <= 1'b0;
      end else begin
         sample_held_o <= (state == DEV_ACQ) && sclk_fall && edge_cnt == CNT_HOLD;
         done_o <= sel_rise && edge_cnt == CNT_FRAME;
         abort_o <= sel_rise && edge_cnt != CNT_FRAME && state != DEV_OFF;
      end
   end
endmodule : sar_dev

/* logic/sar_host.sv */
// master end: drives select and a divided serial clock, collects results
// assumes the converter end sits on the other side of the link interface
`timescale 1ns/1ps
module sar_host
   import sar_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // link
   sar_link_if.host link,
   // request
   input wire logic start_i,
   output logic busy_o,
   // results: 14 result bits over 2 sub-bits
   output logic res_valid_o,
   input wire logic res_ready_i,
   output logic [WORD_W-1:0] res_data_o
);
   typedef enum logic [2:0] {
      H_IDLE,
      H_SETUP,
      H_LOW,
      H_HIGH,
      H_GAP
   } sar_host_state_t;

   sar_host_state_t state;
   logic [TMR_W-1:0] tmr;
   logic [CNT_W-1:0] fall_cnt;
   logic [FRAME_EDGES-1:0] rx;
   logic sel_n;
   logic sclk;
   logic din_m;
   logic din_s;
   logic push;
   logic fifo_ready;
   logic tmr_done;

   assign tmr_done = (tmr == '0);

   // ******************************
   // data input synchroniser
   // ******************************
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         din_m <= 1'b0;
         din_s <= 1'b0;
      end else begin
         din_m <= link.dout_line;
         din_s <= din_m;
      end
   end

   // ******************************
   // frame sequencer
   // ******************************

   // a frame starts only with fifo room, so results never drop
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state <= H_IDLE;
         tmr <= '0;
         sel_n <= 1'b1;
         sclk <= 1'b0;
         fall_cnt <= '0;
         rx <= '0;
      end else begin
         case (state)
            H_IDLE: begin
               if (start_i && fifo_ready) begin
                  sel_n <= 1'b0;
                  tmr <= SETUP_CYC;
                  fall_cnt <= '0;
                  state <= H_SETUP;
               end
            end
            H_SETUP: begin
               if (tmr_done) begin
                  tmr <= HALF_CYC;
                  state <= H_LOW;
               end else begin
                  tmr <= tmr - 1'b1;
               end
            end
            H_LOW: begin
               if (!tmr_done) begin
                  tmr <= tmr - 1'b1;
               end else if (fall_cnt == CNT_FRAME) begin
                  sel_n <= 1'b1;
                  tmr <= GAP_CYC;
                  state <= H_GAP;
               end else begin
                  sclk <= 1'b1;
                  rx <= {rx[FRAME_EDGES-2:0], din_s}; // sample on rise
                  tmr <= HALF_CYC;
                  state <= H_HIGH;
               end
            end
            H_HIGH: begin
               if (tmr_done) begin
                  sclk <= 1'b0;
                  fall_cnt <= fall_cnt + 1'b1;
                  tmr <= HALF_CYC;
                  state <= H_LOW;
               end else begin
                  tmr <= tmr - 1'b1;
               end
            end
            H_GAP: begin
               if (!tmr_done) begin
                  tmr <= tmr - 1'b1;
               end else if (start_i && fifo_ready) begin
                  sel_n <= 1'b0; // back to back at least high time
                  tmr <= SETUP_CYC;
                  fall_cnt <= '0;
                  state <= H_SETUP;
               end else begin
                  state <= H_IDLE;
               end
            end
            default: begin
               state <= H_IDLE;
            end
         endcase
      end
   end

   // push the word as select rises
   assign push = (state == H_LOW) && tmr_done && fall_cnt == CNT_FRAME;
   assign busy_o = (state != H_IDLE);
   assign link.sel_n = sel_n;
   assign link.sclk = sclk;

   // ******************************
   // result buffer
   // ******************************
   sar_fifo #(
      .W(WORD_W),
      .D(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .in_valid_i(push),
      .in_ready_o(fifo_ready),
      .in_data_i(rx[WORD_W-1:0]),
      .out_valid_o(res_valid_o),
      .out_ready_i(res_ready_i),
      .out_data_o(res_data_o)
   );
endmodule : sar_host

/* tb/sar_link_asserts.sv */
// checker for the link between serial master end and converter end
// assumes it watches the first link of the bench, where both ends are design code
`timescale 1ns/1ps
module sar_link_asserts (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // link signals
   input wire logic sel_n,
   input wire logic sclk,
   input wire logic dout,
   input wire logic dout_oe,
   input wire logic dout_line
);
   // ****************************************
   // helper counters
   // ****************************************
   logic sclk_q;
   logic [4:0] nfall;
   logic [7:0] since_fall;
   logic [7:0] since_tog;
   logic [7:0] since_sel;
   logic [10:0] phase_run;
   wire fall_w = sclk_q & ~sclk;

   // saturate so long idle spells cannot wrap into a short count
   function automatic logic [7:0] inc8(input logic [7:0] v);
      return (v == 8'hff) ? v : v + 8'h01;
   endfunction : inc8

   // last clock level, for edge finding
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) sclk_q <= 1'b0;
      else sclk_q <= sclk;
   end

   // falls within one frame; cleared while deselected
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) nfall <= 5'h00;
      else if (sel_n) nfall <= 5'h00;
      else if (fall_w && nfall != 5'h1f) nfall <= nfall + 5'h01;
   end

   // cycles since last fall, last toggle and select low
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         since_fall <= 8'h00;
         since_tog <= 8'h00;
         since_sel <= 8'h00;
         phase_run <= 11'h000;
      end else begin
         since_fall <= fall_w ? 8'h00 : inc8(since_fall);
         since_tog <= (sclk != sclk_q) ? 8'h00 : inc8(since_tog);
         since_sel <= sel_n ? 8'h00 : inc8(since_sel);
         // wider run count for the slow-clock limit, saturating
         phase_run <= (sclk != sclk_q) ? 11'h000 : phase_run + {10'h000, phase_run != 11'h7ff};
      end
   end

   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   // no clock phase inside a frame may last beyond 1000 system cycles
   property slow_clk_p;
      ($changed(sclk) && nfall != 5'h00) |-> phase_run <= 11'h3e8;
   endproperty

   oe_off_a: assert property (sel_n [*5] |-> !dout_oe)
      else $error("data output driven while deselected");
   oe_low_a: assert property ($fell(sel_n) |-> ##5 (dout_oe && !dout))
      else $error("data output not driven low after select fall");
   dout_fall_a: assert property (($changed(dout) && dout_oe) |-> since_fall <= 8'h05)
      else $error("data output moved away from a clock fall");
   lead_zero_a: assert property ((!sel_n && nfall < 5'h08) |-> !dout_line)
      else $error("leading bit not zero");
   trail_zero_a: assert property ((nfall >= 5'h18 && since_fall >= 8'h05) |-> !dout_line)
      else $error("trailing bit not zero");
   frame_len_a: assert property ($rose(sel_n) |-> nfall == 5'h18)
      else $error("frame not closed after exactly 24 falls");
   sclk_half_a: assert property ($changed(sclk) |-> since_tog >= 8'h10)
      else $error("serial clock phase too short");
   slow_clk_a: assert property (slow_clk_p)
      else $error("serial clock phase too long");
   acq_setup_a: assert property (($rose(sclk) && nfall == 5'h00) |-> since_sel >= 8'h13)
      else $error("first clock too soon after select fall");
   sel_gap_a: assert property ($rose(sel_n) |-> sel_n [*8] ##1 sel_n ##1 sel_n)
      else $error("select high time too short");

   // main scenarios
   cover property ($rose(sel_n) && nfall == 5'h18);
   cover property (nfall == 5'h08 && dout_line);
   cover property ($fell(sel_n) ##5 dout_oe);
endmodule : sar_link_asserts

/* tb/test_sar_adc_serial_readout.sv */
// self-checking bench: host and converter joined on one link, bench master on a second
// assumes the link interface resolves a released data line to zero
`timescale 1ns/1ps
module test_sar_adc_serial_readout;
   import sar_pkg::*;
   // ****************************************
   // signals and instances
   // ****************************************
   logic clk_sys_i, rst_i, start, res_ready, busy, res_valid, powered2;
   logic held1, held2, done1, done2, abort1, abort2;
   logic [WORD_W-1:0] res_data;
   logic [RES_W-1:0] ain1, ain2;
   logic [1:0] sub1, sub2;
   int held_c[2], done_c[2], abort_c[2], sfall_c, comparisons, n_mismatch;
   int corner[6] = '{24, 23, 8, 6, 5, 30};
   sar_link_if link1();
   sar_link_if link2();

   sar_host sar_host_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link1.host),
      .start_i(start), .busy_o(busy), .res_valid_o(res_valid), .res_ready_i(res_ready),
      .res_data_o(res_data));
   sar_dev sar_dev_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link1.device),
      .analog_input_i(ain1), .sub_bit_high_i(sub1[1]), .sub_bit_low_i(sub1[0]),
      .powered_o(), .sample_held_o(held1), .done_o(done1), .abort_o(abort1));
   sar_dev sar_dev2_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link2.device),
      .analog_input_i(ain2), .sub_bit_high_i(sub2[1]), .sub_bit_low_i(sub2[0]),
      .powered_o(powered2), .sample_held_o(held2), .done_o(done2), .abort_o(abort2));
   sar_link_asserts sar_link_asserts_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .sel_n(link1.sel_n), .sclk(link1.sclk), .dout(link1.dout), .dout_oe(link1.dout_oe),
      .dout_line(link1.dout_line));

   // pulse counters for both converter ends, plus select falls on the host link
   always @(posedge held1) held_c[0]++;
   always @(posedge held2) held_c[1]++;
   always @(posedge done1) done_c[0]++;
   always @(posedge done2) done_c[1]++;
   always @(posedge abort1) abort_c[0]++;
   always @(posedge abort2) abort_c[1]++;
   always @(negedge link1.sel_n) sfall_c++;

   // 200 MHz system clock
   initial begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end

   // ****************************************
   // tasks and functions
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results

   // bits seen after falls 1..n: seven zeros, result, two sub-bits, then zeros
   function automatic logic [31:0] exp_frame(input int n, input logic [15:0] word);
      logic [31:0] w;
      logic [22:0] f;
      f = {7'h00, word};
      w = 32'h0;
      for (int k = 1; k <= n; k++) w = {w[30:0], (k <= 23) ? f[23-k] : 1'b0};
      return w;
   endfunction : exp_frame

   // bench-made frame of n falls at 80 ns; input differs except across the sixth fall
   task automatic dframe(input int n);
      logic [31:0] got;
      logic [15:0] word;
      got = 32'h0;
      word = 16'($urandom);
      {ain2, sub2} = ~word;
      held_c[1] = 0;
      done_c[1] = 0;
      abort_c[1] = 0;
      link2.sel_n = 1'b0;
      repeat (22) @(negedge clk_sys_i);
      check(link2.dout_oe, 1'b1);
      check(link2.dout_line, 1'b0);
      check(powered2, 1'b1);
      for (int k = 1; k <= n; k++) begin
         link2.sclk = 1'b1;
         repeat (8) @(negedge clk_sys_i);
         link2.sclk = 1'b0;
         repeat (8) @(negedge clk_sys_i);
         got = {got[30:0], link2.dout_line};
         {ain2, sub2} = (k == 5) ? word : ~word;
      end
      link2.sel_n = 1'b1;
      repeat (10) @(negedge clk_sys_i);
      check(got, exp_frame(n, word));
      check(held_c[1], n >= 6);
      check(done_c[1], n >= 24);
      check(abort_c[1], n < 24);
      check(powered2, 1'b0);
      check(link2.dout_oe, 1'b0);
      $display("bench frame of %0d falls done", n);
   endtask : dframe

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      int t;
      rst_i = 1'b1;
      {start, res_ready, ain1, sub1, ain2, sub2} = '0;
      link2.sel_n = 1'b1;
      link2.sclk = 1'b0;
      t = $urandom(81);
      repeat (20) @(negedge clk_sys_i);
      rst_i = 1'b0;
      repeat (2) @(negedge clk_sys_i);
      check({busy, res_valid, link1.sel_n, link2.dout_oe}, 4'h2);
      foreach (corner[i]) dframe(corner[i]);
      repeat (6) dframe(1 + int'($urandom_range(29)));
      // host frames back to back until the buffer refuses
      {ain1, sub1} = 16'($urandom);
      {held_c[0], done_c[0], abort_c[0], sfall_c} = '0;
      start = 1'b1;
      for (t = 0; t < 8000 && !(sfall_c == 4 && !busy); t++) @(negedge clk_sys_i);
      if (t == 8000) begin
         n_mismatch++; // limit ran out
         $display("Error at %0t: host frames did not finish in time", $time);
      end else begin
         repeat (1500) @(negedge clk_sys_i);
         check(sfall_c, 4);
         check(busy, 1'b0);
         check(done_c[0], 4);
         check(held_c[0], 4);
         check(abort_c[0], 0);
         start = 1'b0;
         res_ready = 1'b1;
         for (int i = 0; i < 4; i++) begin
            check(res_valid, 1'b1);
            check(res_data, {ain1, sub1});
            @(negedge clk_sys_i);
         end
         check(res_valid, 1'b0);
         $display("host fill and drain done");
      end
      results();
   end
endmodule : test_sar_adc_serial_readout
